/* File: inc/scan_tap_pkg.sv */
// Shared constants and types for the scan test access port core
package scan_tap_pkg;

    // ==========================================================
    // Widths and fixed patterns
    // ==========================================================
    localparam int          IR_W         = 8;
    localparam logic [7:0]  IR_CAPTURE   = 8'h81;
    localparam logic [7:0]  IR_BYPASS    = 8'hff;
    // Bypass keeps the transceiver in its normal function
    localparam logic [7:0]  IR_DEFAULT   = IR_BYPASS;
    localparam int          NF_W         = 8;
    localparam int          UPD_DEPTH    = 32;
    localparam logic [2:0]  TLR_RUN_LEN  = 3'h5;

    // ==========================================================
    // Controller states
    // ==========================================================
    typedef enum logic [3:0] {
        TAP_TLR     = 4'h0,
        TAP_RTI     = 4'h1,
        TAP_SEL_DR  = 4'h2,
        TAP_CAP_DR  = 4'h3,
        TAP_SH_DR   = 4'h4,
        TAP_EX1_DR  = 4'h5,
        TAP_PAU_DR  = 4'h6,
        TAP_EX2_DR  = 4'h7,
        TAP_UPD_DR  = 4'h8,
        TAP_SEL_IR  = 4'h9,
        TAP_CAP_IR  = 4'ha,
        TAP_SH_IR   = 4'hb,
        TAP_EX1_IR  = 4'hc,
        TAP_PAU_IR  = 4'hd,
        TAP_EX2_IR  = 4'he,
        TAP_UPD_IR  = 4'hf
    } tap_state_t;

    // ==========================================================
    // Record of one register update, pushed into the buffer
    // ==========================================================
    typedef struct packed {
        logic             is_dr;
        logic [IR_W-1:0]  data;
    } upd_rec_t;

    localparam int UPD_W = $bits(upd_rec_t);

endpackage : scan_tap_pkg

/* File: logic/scan_tap_timing_core.sv */
// Scan test access port: controller, instruction and bypass registers, update buffer
`timescale 1ns/10ps

// ==========================================================
// Update record buffer
// ==========================================================
module upd_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Fill side
    input  wire logic         s_valid_i,
    output logic              s_ready_o,
    input  wire logic [W-1:0] s_data_i,
    // Drain side
    output logic              m_valid_o,
    input  wire logic         m_ready_i,
    output logic [W-1:0]      m_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } fifo_st_t;

    fifo_st_t st_r;
    fifo_st_t st_nxt;
    logic     push;
    logic     pop;

    assign s_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
    assign m_valid_o = (st_r.cnt != '0);
    assign m_data_o  = st_r.mem[st_r.rd];
    assign push      = s_valid_i && s_ready_o;
    assign pop       = m_valid_o && m_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = s_data_i;
            st_nxt.wr           = (st_r.wr == AW'(DEPTH-1)) ? '0 : st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = (st_r.rd == AW'(DEPTH-1)) ? '0 : st_r.rd + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Fill-side ready keeps the count at or below the depth
    AST_FIFO_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i) st_r.cnt <= (AW+1)'(DEPTH))
        else $error("Buffer count past depth");

endmodule : upd_fifo

// ==========================================================
// Test access port core
// ==========================================================
module scan_tap_timing_core #(
    parameter int NF_WIDTH  = scan_tap_pkg::NF_W,
    parameter int UPD_DEPTH = scan_tap_pkg::UPD_DEPTH
) (
    // Clock and reset
    input  wire logic                    SYS_CLK_I,
    input  wire logic                    RST_N_I,
    // Four-wire test port
    input  wire logic                    TCK_I,
    input  wire logic                    TMS_I,
    input  wire logic                    TDI_I,
    output logic                         TDO_O,
    output logic                         TDO_OE_N_O,
    // Normal-function pins seen by the test logic
    input  wire logic [NF_WIDTH-1:0]     NF_IN_I,
    output logic [NF_WIDTH-1:0]          NF_OUT_O,
    // Controller status
    output scan_tap_pkg::tap_state_t     TAP_STATE_O,
    output logic [scan_tap_pkg::IR_W-1:0] INSTR_O,
    output logic                         BYPASS_SEL_O,
    // Update record stream
    output logic                         UPD_FILL_READY_O,
    output logic                         UPD_VALID_O,
    input  wire logic                    UPD_READY_I,
    output scan_tap_pkg::upd_rec_t       UPD_DATA_O
);
    import scan_tap_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic                tck_m;
        logic                tck_s;
        logic                tck_p;
        logic                tms_m;
        logic                tms_s;
        logic                tdi_m;
        logic                tdi_s;
        logic [NF_WIDTH-1:0] nf_m;
        logic [NF_WIDTH-1:0] nf_s;
        tap_state_t          tap;
        logic [IR_W-1:0]     ir_sh;
        logic [IR_W-1:0]     ir_act;
        logic                byp;
        logic                dr_shadow;
        logic                tdo;
        logic                tdo_oe_n;
        logic [NF_WIDTH-1:0] nf_cap;
        logic [NF_WIDTH-1:0] nf_out;
        logic                push;
        upd_rec_t            rec;
    } core_st_t;

    localparam core_st_t ST_RST = '{
        tap:      TAP_TLR,
        ir_act:   IR_DEFAULT,
        tdo_oe_n: 1'b1,
        default:  '0
    };

    core_st_t st_r;
    core_st_t st_nxt;
    logic     tck_rise;
    logic     tck_fall;
    logic     bypass_sel;
    logic     fill_ready;

    // Edges found on the synchronised clock; TMS/TDI share its delay
    assign tck_rise   = st_r.tck_s && !st_r.tck_p;
    assign tck_fall   = !st_r.tck_s && st_r.tck_p;
    assign bypass_sel = (st_r.ir_act == IR_BYPASS);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_nxt       = st_r;
        st_nxt.push  = 1'b0;
        // Two-flop synchronisers for everything off-chip
        st_nxt.tck_m = TCK_I;
        st_nxt.tck_s = st_r.tck_m;
        st_nxt.tck_p = st_r.tck_s;
        st_nxt.tms_m = TMS_I;
        st_nxt.tms_s = st_r.tms_m;
        st_nxt.tdi_m = TDI_I;
        st_nxt.tdi_s = st_r.tdi_m;
        st_nxt.nf_m  = NF_IN_I;
        st_nxt.nf_s  = st_r.nf_m;

        if (tck_rise) begin
            st_nxt.nf_cap = st_r.nf_s;
            // Register actions use the state being left
            unique case (st_r.tap)
                TAP_CAP_IR: st_nxt.ir_sh = IR_CAPTURE;
                TAP_SH_IR:  st_nxt.ir_sh = {st_r.tdi_s, st_r.ir_sh[IR_W-1:1]};
                // No other data register is built, so every instruction scans bypass
                TAP_CAP_DR: st_nxt.byp = 1'b0;
                TAP_SH_DR:  st_nxt.byp = st_r.tdi_s;
                default:    st_nxt.byp = st_r.byp;
            endcase
            // Transition graph, one step per rising edge
            unique case (st_r.tap)
                TAP_TLR:    st_nxt.tap = st_r.tms_s ? TAP_TLR    : TAP_RTI;
                TAP_RTI:    st_nxt.tap = st_r.tms_s ? TAP_SEL_DR : TAP_RTI;
                TAP_SEL_DR: st_nxt.tap = st_r.tms_s ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: st_nxt.tap = st_r.tms_s ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR:  st_nxt.tap = st_r.tms_s ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: st_nxt.tap = st_r.tms_s ? TAP_UPD_DR : TAP_PAU_DR;
                TAP_PAU_DR: st_nxt.tap = st_r.tms_s ? TAP_EX2_DR : TAP_PAU_DR;
                TAP_EX2_DR: st_nxt.tap = st_r.tms_s ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: st_nxt.tap = st_r.tms_s ? TAP_SEL_DR : TAP_RTI;
                TAP_SEL_IR: st_nxt.tap = st_r.tms_s ? TAP_TLR    : TAP_CAP_IR;
                TAP_CAP_IR: st_nxt.tap = st_r.tms_s ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR:  st_nxt.tap = st_r.tms_s ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: st_nxt.tap = st_r.tms_s ? TAP_UPD_IR : TAP_PAU_IR;
                TAP_PAU_IR: st_nxt.tap = st_r.tms_s ? TAP_EX2_IR : TAP_PAU_IR;
                TAP_EX2_IR: st_nxt.tap = st_r.tms_s ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: st_nxt.tap = st_r.tms_s ? TAP_SEL_DR : TAP_RTI;
            endcase
        end

        if (tck_fall) begin
            st_nxt.nf_out = st_r.nf_cap;
            unique case (st_r.tap)
                TAP_SH_IR: begin
                    st_nxt.tdo      = st_r.ir_sh[0];
                    st_nxt.tdo_oe_n = 1'b0;
                end
                TAP_SH_DR: begin
                    st_nxt.tdo      = st_r.byp;
                    st_nxt.tdo_oe_n = 1'b0;
                end
                TAP_EX1_IR, TAP_EX1_DR: begin
                    st_nxt.tdo_oe_n = 1'b1;
                end
                TAP_UPD_IR: begin
                    st_nxt.ir_act = st_r.ir_sh;
                    st_nxt.rec    = '{is_dr: 1'b0, data: st_r.ir_sh};
                    st_nxt.push   = 1'b1;
                end
                TAP_UPD_DR: begin
                    st_nxt.dr_shadow = st_r.byp;
                    st_nxt.rec       = '{is_dr: 1'b1, data: {{(IR_W-1){1'b0}}, st_r.byp}};
                    st_nxt.push      = 1'b1;
                end
                default: begin
                    st_nxt.tdo = st_r.tdo;
                end
            endcase
        end

        // Reset state forces the default on every system clock, with or without test clock edges
        if (st_r.tap == TAP_TLR) begin
            st_nxt.ir_act = IR_DEFAULT;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Update record buffer; a full buffer drops the record
    // ==========================================================
    upd_fifo #(
        .W     (UPD_W),
        .DEPTH (UPD_DEPTH)
    ) u_upd_fifo (
        .clk_i     (SYS_CLK_I),
        .rst_n_i   (RST_N_I),
        .s_valid_i (st_r.push),
        .s_ready_o (fill_ready),
        .s_data_i  (st_r.rec),
        .m_valid_o (UPD_VALID_O),
        .m_ready_i (UPD_READY_I),
        .m_data_o  (UPD_DATA_O)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign TDO_O            = st_r.tdo;
    assign TDO_OE_N_O       = st_r.tdo_oe_n;
    assign NF_OUT_O         = st_r.nf_out;
    assign TAP_STATE_O      = st_r.tap;
    assign INSTR_O          = st_r.ir_act;
    assign BYPASS_SEL_O     = bypass_sel;
    assign UPD_FILL_READY_O = fill_ready;

    // ==========================================================
    // Checks
    // ==========================================================
    logic [2:0] tms_run_r;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tms_run_r <= 3'h0;
        end else if (tck_rise) begin
            tms_run_r <= !st_r.tms_s ? 3'h0 : (tms_run_r == TLR_RUN_LEN) ? tms_run_r : tms_run_r + 3'h1;
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_rise_in(tap_state_t s);
        tck_rise && st_r.tap == s;
    endsequence

    sequence s_fall_in(tap_state_t s);
        tck_fall && st_r.tap == s;
    endsequence

    AST_TLR_EXIT: assert property (s_rise_in(TAP_TLR) ##0 !st_r.tms_s |=> st_r.tap == TAP_RTI)
        else $error("Reset state not left on TMS low");
    AST_CAP_IR: assert property (s_rise_in(TAP_CAP_IR) |=> st_r.ir_sh == IR_CAPTURE)
        else $error("Capture pattern not loaded");
    AST_SHIFT_IR: assert property (s_rise_in(TAP_SH_IR) |=>
            st_r.ir_sh == {$past(st_r.tdi_s), $past(st_r.ir_sh[IR_W-1:1])})
        else $error("Instruction shift wrong");
    AST_TDO_ON_FALL: assert property (!tck_fall |=> $stable(TDO_O) && $stable(TDO_OE_N_O))
        else $error("TDO changed away from falling edge");
    AST_OE_ON: assert property ((s_fall_in(TAP_SH_IR) or s_fall_in(TAP_SH_DR)) |=> !TDO_OE_N_O)
        else $error("TDO not driven in shift");
    AST_OE_OFF: assert property ((s_fall_in(TAP_EX1_IR) or s_fall_in(TAP_EX1_DR)) |=> TDO_OE_N_O)
        else $error("TDO not released in exit");
    AST_UPD_IR: assert property (s_fall_in(TAP_UPD_IR) |=> INSTR_O == $past(st_r.ir_sh))
        else $error("Instruction not latched");
    AST_BYP_CAP: assert property (s_rise_in(TAP_CAP_DR) |=> !st_r.byp)
        else $error("Bypass capture not zero");
    AST_FIVE_ONES: assert property (tms_run_r == TLR_RUN_LEN |-> st_r.tap == TAP_TLR)
        else $error("Five TMS-high edges missed reset state");
    AST_DEFAULT: assert property (st_r.tap == TAP_TLR |=> INSTR_O == IR_DEFAULT)
        else $error("Default instruction not restored");
    AST_BYP_SHIFT: assert property (s_rise_in(TAP_SH_DR) |=> st_r.byp == $past(st_r.tdi_s))
        else $error("Bypass stage did not take TDI");
    AST_UPD_DR: assert property (s_fall_in(TAP_UPD_DR) |=> st_r.dr_shadow == $past(st_r.byp))
        else $error("Data shadow not updated");
    AST_NF_OUT: assert property (tck_fall |=> NF_OUT_O == $past(st_r.nf_cap))
        else $error("Normal output not presented on fall");

endmodule : scan_tap_timing_core

/* File: testbench/scan_master.sv */
// Test master model driving the four-wire scan port
`timescale 1ns/10ps

module scan_master (
    // Port wires
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_n_i
);
    logic last_r;

    initial begin
        tck_o  = 1'b0;
        tms_o  = 1'b1;
        tdi_o  = 1'b1;
        last_r = 1'b0;
    end

    // ==========================================================
    // One TCK cycle, TDO as seen just before the rise
    // ==========================================================
    task automatic cyc(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
        // Entered just after a fall, so TMS and TDI change in the low phase
        tms_o = tms;
        tdi_o = tdi;
        #200;
        oe_n = tdo_oe_n_i;
        // Released line has no pull: show the opposite of the last bit seen, driven or not
        tdo = tdo_oe_n_i ? ~last_r : tdo_i;
        last_r = tdo;
        tck_o = 1'b1;
        #200;
        // Clock stands low between calls
        tck_o = 1'b0;
    endtask : cyc
endmodule : scan_master

/* File: testbench/tb.sv */
// Self-checking bench for the scan test access port core
`timescale 1ns/10ps

module tb;
    import scan_tap_pkg::*;
    logic sys_clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, upd_ready, fill_rdy, upd_valid, byp_sel;
    logic so, oo, drain_en, rdy_nxt;
    logic [NF_W-1:0] nf_in, nf_out;
    logic [IR_W-1:0] instr;
    tap_state_t state;
    upd_rec_t upd_data;
    upd_rec_t exp_q[$];
    int error_cnt, total_checks;

    scan_tap_timing_core u_dut (
        .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n), .NF_IN_I(nf_in), .NF_OUT_O(nf_out),
        .TAP_STATE_O(state), .INSTR_O(instr), .BYPASS_SEL_O(byp_sel),
        .UPD_FILL_READY_O(fill_rdy), .UPD_VALID_O(upd_valid), .UPD_READY_I(upd_ready),
        .UPD_DATA_O(upd_data)
    );

    scan_master u_master (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n)
    );

    // ==========================================================
    // Compare and report
    // ==========================================================
    task automatic chk1(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1

    task automatic chkv(input logic [8:0] got, input logic [8:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chkv

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // Drop on a full buffer, as the device does
    function automatic void push_exp(input upd_rec_t r);
        if (exp_q.size() < UPD_DEPTH) begin
            exp_q.push_back(r);
        end
    endfunction : push_exp

    // ==========================================================
    // Link steps and scans
    // ==========================================================
    task automatic step(input logic m, input logic d);
        logic [NF_W-1:0] prev;
        prev = nf_in;
        @(negedge sys_clk);
        nf_in = NF_W'($urandom);
        fork
            u_master.cyc(m, d, so, oo);
            begin
                #190;
                chkv(9'(nf_out), 9'(prev), "nf_out");
            end
        join
    endtask : step

    task automatic run_tms(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++) begin
            step(pat[i], 1'b1);
        end
    endtask : run_tms

    task automatic scan_ir(input logic [7:0] ir);
        run_tms(8'h03, 4);
        for (int i = 0; i < IR_W; i++) begin
            step(i == IR_W - 1, ir[i]);
            chk1(oo, 1'b0, "oe shift-ir");
            chk1(so, IR_CAPTURE[i], "tdo ir");
        end
        step(1'b1, 1'b1);
        chk1(oo, 1'b1, "oe exit1-ir");
        push_exp({1'b0, ir});
        step(1'b0, 1'b1);
        chkv(9'(instr), 9'(ir), "instr");
        chk1(byp_sel, ir == IR_BYPASS, "bypass sel");
    endtask : scan_ir

    task automatic scan_dr(input logic [7:0] b, input int n);
        run_tms(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, b[i]);
            chk1(oo, 1'b0, "oe shift-dr");
            chk1(so, (i == 0) ? 1'b0 : b[i-1], "tdo dr");
        end
        step(1'b1, 1'b1);
        chk1(oo, 1'b1, "oe exit1-dr");
        push_exp({1'b1, 7'h00, b[n-1]});
        step(1'b0, 1'b1);
    endtask : scan_dr

    task automatic drain();
        drain_en = 1'b1;
        for (int t = 0; t < 5000 && exp_q.size() != 0; t++) begin
            @(negedge sys_clk);
        end
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("[FAIL] %0t drain timed out", $time);
            conclude();
        end
    endtask : drain

    // ==========================================================
    // Clock, consumer with random stalls, watchdog
    // ==========================================================
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Pop decided at the fall, where valid and data stand settled until the next rise
    always @(negedge sys_clk) begin
        rdy_nxt = drain_en & 1'($urandom);
        if (upd_valid === 1'b1 && rdy_nxt === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk1(1'b1, 1'b0, "unexpected record");
            end else begin
                chkv(upd_data, exp_q.pop_front(), "record");
            end
        end
        upd_ready <= rdy_nxt;
    end

    initial begin
        repeat (80000) @(posedge sys_clk);
        error_cnt++;
        $display("[FAIL] %0t run timed out", $time);
        conclude();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        rst_n = 1'b0;
        nf_in = '0;
        drain_en = 1'b1;
        upd_ready = 1'b0;
        error_cnt = 0;
        total_checks = 0;
        void'($urandom(79471));
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chkv(9'(state), 9'(TAP_TLR), "reset state");
        chkv(9'(instr), 9'(IR_DEFAULT), "reset instr");
        chk1(tdo_oe_n, 1'b1, "reset oe");
        step(1'b0, 1'b1);
        chkv(9'(state), 9'(TAP_RTI), "leave reset");
        $display("test reset done");
        // Corner instructions first, then random ones
        for (int k = 0; k < 5; k++) begin
            scan_ir((k == 0) ? 8'h00 : (k == 1) ? IR_BYPASS : 8'($urandom));
            scan_dr(8'($urandom), k + 1);
        end
        scan_dr(8'h05, 3);
        $display("test scans done");
        // Five high TMS edges from idle, Shift-DR, Pause-DR and Pause-IR
        drain();
        drain_en = 1'b0;
        for (int k = 0; k < 4; k++) begin
            scan_ir(8'($urandom) & 8'h7f);
            if (k == 1) begin
                run_tms(8'h01, 3);
            end
            if (k == 2) begin
                run_tms(8'h05, 4);
            end
            if (k == 3) begin
                run_tms(8'h0b, 5);
            end
            run_tms(8'h1f, 5);
            if (k != 0) begin
                push_exp((k == 3) ? {1'b0, IR_CAPTURE} : {1'b1, 7'h00, k == 1});
            end
            chkv(9'(state), 9'(TAP_TLR), "five ones");
            chkv(9'(instr), 9'(IR_DEFAULT), "default instr");
            step(1'b0, 1'b1);
        end
        drain();
        $display("test return to reset done");
        // Fill the record buffer past full, then drain with stalls
        drain_en = 1'b0;
        for (int k = 0; k < UPD_DEPTH + 2; k++) begin
            scan_dr(8'($urandom), 1);
        end
        chk1(fill_rdy, 1'b0, "buffer full");
        drain();
        repeat (4) @(negedge sys_clk);
        chk1(upd_valid, 1'b0, "buffer empty");
        chk1(fill_rdy, 1'b1, "buffer ready");
        $display("test buffer done");
        conclude();
    end
endmodule : tb
